// ==== hdl/sfr_cfg.svh ====
// Constants for the serial flash read and protection block.
`ifndef SFR_CFG_SVH
`define SFR_CFG_SVH

// Instruction codes.
`define SFR_CMD_READ 8'h03
`define SFR_CMD_FAST 8'h0b
`define SFR_CMD_DOUT 8'h3b
`define SFR_CMD_DIO 8'hbb
`define SFR_CMD_QOUT 8'h6b
`define SFR_CMD_WRITE_ENABLE_CMD 8'h06
`define SFR_CMD_SWRITE 8'h01

// Link edge counts, as last index of each phase, plus the edge saturation value and whole-frame edge totals.
`define SFR_CMD_LAST 6'h07
`define SFR_SR_LAST 6'h0f
`define SFR_CR_LAST 6'h17
`define SFR_EDGE_MAX 6'h3f
`define SFR_ADDR_LAST_SINGLE 5'h17
`define SFR_ADDR_LAST_DUAL 5'h0b
`define SFR_DUMMY_LAST_FAST 5'h07
`define SFR_DUMMY_LAST_DOUT 5'h07
`define SFR_DUMMY_LAST_QOUT 5'h07
`define SFR_DUMMY_LAST_DIO 5'h03
`define SFR_FRAME_WRITE_ENABLE_CMD 6'h08
`define SFR_FRAME_SR 6'h10
`define SFR_FRAME_SRCR 6'h18

// Status byte field positions and configuration byte field.
`define SFR_SR_LOCK_BIT 7
`define SFR_SR_QE_BIT 6
`define SFR_SR_BP_HI 5
`define SFR_SR_BP_LO 2
`define SFR_CR_TB_BIT 3

// Reset values of the status bits.
`define SFR_LOCK_RST 1'b0
`define SFR_QE_RST 1'b0
`define SFR_BP_RST 4'h0
`define SFR_TB_RST 1'b0

// Array geometry and protection granule.
`define SFR_MEM_AW 12
`define SFR_MEM_BYTES 4096
`define SFR_ADDR_TOP 25'h100_0000
`define SFR_PROT_BASE_LOG2 5'h0f
`define SFR_PROT_MAX_LOG2 5'h18
`define SFR_ERASED_BYTE 8'hff

// Internal cycle times.
`define SFR_REF_MHZ 100
`define SFR_STATUS_WRITE_NS 2000
`define SFR_PROG_NS 1000
`define SFR_STATUS_WRITE_CYC ((`SFR_STATUS_WRITE_NS * `SFR_REF_MHZ + 999) / 1000)
`define SFR_PROG_CYC ((`SFR_PROG_NS * `SFR_REF_MHZ + 999) / 1000)

`endif

// ==== hdl/sfr_pkg.sv ====
// Types shared by the serial flash read and protection block.
package sfr_pkg;
	typedef enum logic [2:0] {
		SFR_LS_CMD,
		SFR_LS_ADDR,
		SFR_LS_DUMMY,
		SFR_LS_DATA,
		SFR_LS_WDATA,
		SFR_LS_IGNORE
	} sfr_link_state_t;

	typedef enum logic [2:0] {
		SFR_RM_READ,
		SFR_RM_FAST,
		SFR_RM_DOUT,
		SFR_RM_DIO,
		SFR_RM_QOUT
	} sfr_read_mode_t;

	typedef enum logic [1:0] {
		SFR_CS_IDLE,
		SFR_CS_SWRITE,
		SFR_CS_PROG,
		SFR_CS_ERASE
	} sfr_core_state_t;
endpackage

// ==== hdl/sfr_sync.sv ====
// Three-stage synchroniser with agreement filter on the last two stages.
`timescale 1ns/100ps
`default_nettype none
module sfr_sync #(
	parameter logic RST_VAL = 1'b0
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic d_in,
	output logic q_out
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic f_q;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s1_q <= RST_VAL;
			s2_q <= RST_VAL;
			s3_q <= RST_VAL;
			f_q <= RST_VAL;
		end else begin
			s1_q <= d_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				f_q <= s3_q;
			end
		end
	end

	assign q_out = f_q;
endmodule // sfr_sync
`default_nettype wire

// ==== hdl/sfr_top.sv ====
// Serial flash read path, status write and protection state logic.
`timescale 1ns/100ps
`default_nettype none
`include "sfr_cfg.svh"

module sfr_top (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic sclk_in,
	input wire logic cs_n_in,
	input wire logic io_line_0_in,
	output logic io_line_0_out,
	output logic io_line_0_oe_out,
	input wire logic io_line_1_in,
	output logic io_line_1_out,
	output logic io_line_1_oe_out,
	input wire logic io_line_2_in,
	output logic io_line_2_out,
	output logic io_line_2_oe_out,
	input wire logic io_line_3_in,
	output logic io_line_3_out,
	output logic io_line_3_oe_out,
	input wire logic prog_req_in,
	input wire logic erase_req_in,
	input wire logic [23:0] prog_addr_in,
	input wire logic [7:0] prog_data_in,
	output logic status_write_lock_out,
	output logic quad_enable_bit_out,
	output logic [3:0] block_protect_bits_out,
	output logic protect_region_select_out,
	output logic write_latch_out,
	output logic busy_out,
	output logic hardware_protect_state_out,
	output logic software_protect_state_out,
	output logic refused_out
);
	// Array shared by the core (writes) and the link (reads).
	logic [7:0] mem_q [`SFR_MEM_BYTES];

	function automatic logic sfr_is_protected(input logic [23:0] a, input logic [3:0] bp,
		input logic tb);
		logic [4:0] sh;
		logic [24:0] sz;
		logic res;
		sh = `SFR_PROT_BASE_LOG2 + {1'b0, bp};
		if (sh > `SFR_PROT_MAX_LOG2) begin
			sh = `SFR_PROT_MAX_LOG2;
		end
		sz = 25'h000_0001 << sh;
		if (bp == 4'h0) begin
			res = 1'b0;
		end else if (tb) begin
			res = {1'b0, a} < sz;
		end else begin
			res = {1'b0, a} >= (`SFR_ADDR_TOP - sz);
		end
		return res;
	endfunction

	// Link domain, clocked by the serial clock and cleared while chip select is high.
	logic link_rst_n;
	sfr_pkg::sfr_link_state_t lstate_q, lstate_d;
	sfr_pkg::sfr_read_mode_t mode_q, mode_d, cmd_mode;
	logic [5:0] edge_cnt_q, edge_cnt_d;
	logic [4:0] pcnt_q, pcnt_d;
	logic [2:0] dcnt_q, dcnt_d;
	logic [23:0] ashift_q, ashift_d;
	logic [23:0] addr_q, addr_d;
	logic [7:0] dshift_q, dshift_d;
	logic [3:0] io_out_q, io_oe_q;
	logic [7:0] cmd_hold_q, sr_hold_q, cr_hold_q;
	logic [5:0] frame_bits_q;
	logic busy_link;
	logic cmd_is_read;
	logic [7:0] shift_byte;
	logic [23:0] single_in, dual_in, addr_in_full;
	logic [4:0] addr_last, dummy_last;
	logic [2:0] cpb_last;
	logic [7:0] mem_rd_new, mem_rd_cur;
	logic [3:0] out_d, oe_d;

	// Chip select high acts as the frame's own reset, since the serial clock may stop.
	assign link_rst_n = rst_n_in & ~cs_n_in;

	// Bits arrive most significant first.
	assign shift_byte = {ashift_q[6:0], io_line_0_in};
	assign single_in = {ashift_q[22:0], io_line_0_in};
	assign dual_in = {ashift_q[21:0], io_line_1_in, io_line_0_in};
	assign addr_in_full = (mode_q == sfr_pkg::SFR_RM_DIO) ? dual_in : single_in;
	assign mem_rd_new = mem_q[addr_in_full[`SFR_MEM_AW-1:0]];
	assign mem_rd_cur = mem_q[addr_q[`SFR_MEM_AW-1:0]];
	assign edge_cnt_d = (edge_cnt_q == `SFR_EDGE_MAX) ? edge_cnt_q : edge_cnt_q + 6'h01;

	assign addr_last = (mode_q == sfr_pkg::SFR_RM_DIO) ? `SFR_ADDR_LAST_DUAL
		: `SFR_ADDR_LAST_SINGLE;
	assign cpb_last = (mode_q == sfr_pkg::SFR_RM_QOUT) ? 3'h1
		: ((mode_q == sfr_pkg::SFR_RM_DOUT) || (mode_q == sfr_pkg::SFR_RM_DIO)) ? 3'h3 : 3'h7;

	always_comb begin
		cmd_is_read = 1'b1;
		cmd_mode = sfr_pkg::SFR_RM_READ;
		dummy_last = 5'h00;
		unique case (shift_byte)
			`SFR_CMD_READ: cmd_mode = sfr_pkg::SFR_RM_READ;
			`SFR_CMD_FAST: cmd_mode = sfr_pkg::SFR_RM_FAST;
			`SFR_CMD_DOUT: cmd_mode = sfr_pkg::SFR_RM_DOUT;
			`SFR_CMD_DIO: cmd_mode = sfr_pkg::SFR_RM_DIO;
			`SFR_CMD_QOUT: cmd_mode = sfr_pkg::SFR_RM_QOUT;
			default: cmd_is_read = 1'b0;
		endcase
		unique case (mode_q)
			sfr_pkg::SFR_RM_FAST: dummy_last = `SFR_DUMMY_LAST_FAST;
			sfr_pkg::SFR_RM_DOUT: dummy_last = `SFR_DUMMY_LAST_DOUT;
			sfr_pkg::SFR_RM_DIO: dummy_last = `SFR_DUMMY_LAST_DIO;
			sfr_pkg::SFR_RM_QOUT: dummy_last = `SFR_DUMMY_LAST_QOUT;
			sfr_pkg::SFR_RM_READ: dummy_last = 5'h00;
		endcase
	end

	always_comb begin
		lstate_d = lstate_q;
		mode_d = mode_q;
		pcnt_d = pcnt_q;
		dcnt_d = dcnt_q;
		ashift_d = ashift_q;
		addr_d = addr_q;
		dshift_d = dshift_q;
		unique case (lstate_q)
			sfr_pkg::SFR_LS_CMD: begin
				ashift_d = single_in;
				if (edge_cnt_q == `SFR_CMD_LAST) begin
					pcnt_d = 5'h00;
					mode_d = cmd_mode;
					if (cmd_is_read) begin
						if (busy_link && (cmd_mode != sfr_pkg::SFR_RM_READ)) begin
							lstate_d = sfr_pkg::SFR_LS_IGNORE;
						end else begin
							lstate_d = sfr_pkg::SFR_LS_ADDR;
						end
					end else if (shift_byte == `SFR_CMD_SWRITE) begin
						lstate_d = sfr_pkg::SFR_LS_WDATA;
					end else begin
						lstate_d = sfr_pkg::SFR_LS_IGNORE;
					end
				end
			end
			sfr_pkg::SFR_LS_ADDR: begin
				ashift_d = addr_in_full;
				pcnt_d = pcnt_q + 5'h01;
				if (pcnt_q == addr_last) begin
					pcnt_d = 5'h00;
					addr_d = addr_in_full;
					// plain read goes straight to data
					if (mode_q == sfr_pkg::SFR_RM_READ) begin
						dshift_d = mem_rd_new;
						addr_d = addr_in_full + 24'h00_0001;
						dcnt_d = 3'h0;
						lstate_d = sfr_pkg::SFR_LS_DATA;
					end else begin
						lstate_d = sfr_pkg::SFR_LS_DUMMY;
					end
				end
			end
			sfr_pkg::SFR_LS_DUMMY: begin
				pcnt_d = pcnt_q + 5'h01;
				if (pcnt_q == dummy_last) begin
					dshift_d = mem_rd_cur;
					addr_d = addr_q + 24'h00_0001;
					dcnt_d = 3'h0;
					lstate_d = sfr_pkg::SFR_LS_DATA;
				end
			end
			sfr_pkg::SFR_LS_DATA: begin
				dcnt_d = dcnt_q + 3'h1;
				if (dcnt_q == cpb_last) begin
					dshift_d = mem_rd_cur;
					addr_d = addr_q + 24'h00_0001;
					dcnt_d = 3'h0;
				end else if (mode_q == sfr_pkg::SFR_RM_QOUT) begin
					dshift_d = {dshift_q[3:0], 4'h0};
				end else if ((mode_q == sfr_pkg::SFR_RM_DOUT) || (mode_q == sfr_pkg::SFR_RM_DIO)) begin
					dshift_d = {dshift_q[5:0], 2'h0};
				end else begin
					dshift_d = {dshift_q[6:0], 1'b0};
				end
			end
			sfr_pkg::SFR_LS_WDATA: ashift_d = single_in;
			sfr_pkg::SFR_LS_IGNORE: ashift_d = ashift_q;
		endcase
	end

	always_ff @(posedge sclk_in or negedge link_rst_n) begin
		if (!link_rst_n) begin
			lstate_q <= sfr_pkg::SFR_LS_CMD;
			mode_q <= sfr_pkg::SFR_RM_READ;
			edge_cnt_q <= 6'h00;
			pcnt_q <= 5'h00;
			dcnt_q <= 3'h0;
			ashift_q <= 24'h00_0000;
			addr_q <= 24'h00_0000;
			dshift_q <= 8'h00;
		end else begin
			lstate_q <= lstate_d;
			mode_q <= mode_d;
			edge_cnt_q <= edge_cnt_d;
			pcnt_q <= pcnt_d;
			dcnt_q <= dcnt_d;
			ashift_q <= ashift_d;
			addr_q <= addr_d;
			dshift_q <= dshift_d;
		end
	end

	// Frame words survive chip select high so the core can read them after the frame.
	always_ff @(posedge sclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cmd_hold_q <= 8'h00;
			sr_hold_q <= 8'h00;
			cr_hold_q <= 8'h00;
			frame_bits_q <= 6'h00;
		end else begin
			frame_bits_q <= (edge_cnt_q == 6'h00) ? 6'h01 : edge_cnt_d;
			if (edge_cnt_q == `SFR_CMD_LAST) begin
				cmd_hold_q <= shift_byte;
			end
			if (edge_cnt_q == `SFR_SR_LAST) begin
				sr_hold_q <= shift_byte;
			end
			if (edge_cnt_q == `SFR_CR_LAST) begin
				cr_hold_q <= shift_byte;
			end
		end
	end

	// dual data on lines 1 and 0
	assign out_d = (mode_q == sfr_pkg::SFR_RM_QOUT) ? dshift_q[7:4]
		: ((mode_q == sfr_pkg::SFR_RM_DOUT) || (mode_q == sfr_pkg::SFR_RM_DIO))
		? {2'h0, dshift_q[7:6]} : {2'h0, dshift_q[7], 1'b0};
	// quad data on lines 3 to 0
	assign oe_d = (lstate_q != sfr_pkg::SFR_LS_DATA) ? 4'h0
		: (mode_q == sfr_pkg::SFR_RM_QOUT) ? 4'hf
		: ((mode_q == sfr_pkg::SFR_RM_DOUT) || (mode_q == sfr_pkg::SFR_RM_DIO)) ? 4'h3 : 4'h2;

	always_ff @(negedge sclk_in or negedge link_rst_n) begin
		if (!link_rst_n) begin
			io_out_q <= 4'h0;
			io_oe_q <= 4'h0;
		end else begin
			io_out_q <= out_d;
			io_oe_q <= oe_d;
		end
	end

	assign io_line_0_out = io_out_q[0];
	assign io_line_1_out = io_out_q[1];
	assign io_line_2_out = io_out_q[2];
	assign io_line_3_out = io_out_q[3];
	assign io_line_0_oe_out = io_oe_q[0];
	assign io_line_1_oe_out = io_oe_q[1];
	assign io_line_2_oe_out = io_oe_q[2];
	assign io_line_3_oe_out = io_oe_q[3];

	// Core domain.
	sfr_pkg::sfr_core_state_t cstate_q, cstate_d;
	logic lock_q, lock_d;
	logic qe_q, qe_d;
	logic [3:0] bp_q, bp_d;
	logic tb_q, tb_d;
	logic latch_q, latch_d;
	logic hw_q, hw_d;
	logic refused_q, refused_d;
	logic cs_prev_q;
	logic [15:0] cnt_q, cnt_d;
	logic [1:0] sync_in, sync_out;
	logic cs_hi, wp_level, cs_rise, write_enable_cmd_ev, swr_ev, busy;
	logic mem_we;
	logic [`SFR_MEM_AW-1:0] mem_waddr;
	logic [7:0] mem_wdata;

	assign sync_in = {io_line_2_in, cs_n_in};

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_ref_sync
			sfr_sync #(.RST_VAL(1'b1)) u_sync (
				.clk_in(ref_clk_in),
				.rst_n_in(rst_n_in),
				.d_in(sync_in[gi]),
				.q_out(sync_out[gi])
			);
		end
	endgenerate

	// Busy level seen by the link; seven link edges pass before any command decision.
	sfr_sync #(.RST_VAL(1'b0)) u_busy_sync (
		.clk_in(sclk_in),
		.rst_n_in(rst_n_in),
		.d_in(busy),
		.q_out(busy_link)
	);

	assign cs_hi = sync_out[0];
	assign wp_level = sync_out[1];
	assign cs_rise = cs_hi & ~cs_prev_q;
	assign busy = (cstate_q != sfr_pkg::SFR_CS_IDLE);
	assign write_enable_cmd_ev = cs_rise && (cmd_hold_q == `SFR_CMD_WRITE_ENABLE_CMD) && (frame_bits_q == `SFR_FRAME_WRITE_ENABLE_CMD);
	assign swr_ev = cs_rise && (cmd_hold_q == `SFR_CMD_SWRITE)
		&& ((frame_bits_q == `SFR_FRAME_SR) || (frame_bits_q == `SFR_FRAME_SRCR));
	// pin high is the only exit
	assign hw_d = lock_q & ~wp_level & ~qe_q;

	always_comb begin
		cstate_d = cstate_q;
		lock_d = lock_q;
		qe_d = qe_q;
		bp_d = bp_q;
		tb_d = tb_q;
		latch_d = latch_q;
		refused_d = 1'b0;
		cnt_d = cnt_q + 16'h0001;
		mem_we = 1'b0;
		mem_waddr = prog_addr_in[`SFR_MEM_AW-1:0];
		mem_wdata = mem_q[prog_addr_in[`SFR_MEM_AW-1:0]] & prog_data_in;
		unique case (cstate_q)
			sfr_pkg::SFR_CS_IDLE: begin
				cnt_d = 16'h0000;
				if (write_enable_cmd_ev) begin
					// write enable at any pin level
					latch_d = 1'b1;
				end else if (swr_ev) begin
					if (latch_q && !hw_q) begin
						lock_d = sr_hold_q[`SFR_SR_LOCK_BIT];
						qe_d = sr_hold_q[`SFR_SR_QE_BIT];
						bp_d = sr_hold_q[`SFR_SR_BP_HI:`SFR_SR_BP_LO];
						if (frame_bits_q == `SFR_FRAME_SRCR) begin
							tb_d = tb_q | cr_hold_q[`SFR_CR_TB_BIT];
						end
						cstate_d = sfr_pkg::SFR_CS_SWRITE;
					end else begin
						refused_d = 1'b1;
					end
				end else if (prog_req_in || erase_req_in) begin
					if (latch_q && !sfr_is_protected(prog_addr_in, bp_q, tb_q)) begin
						if (prog_req_in) begin
							mem_we = 1'b1;
							cstate_d = sfr_pkg::SFR_CS_PROG;
						end else begin
							cstate_d = sfr_pkg::SFR_CS_ERASE;
						end
					end else begin
						refused_d = 1'b1;
					end
				end
			end
			sfr_pkg::SFR_CS_SWRITE: begin
				if (cnt_q == 16'(`SFR_STATUS_WRITE_CYC - 1)) begin
					latch_d = 1'b0;
					cstate_d = sfr_pkg::SFR_CS_IDLE;
				end
			end
			sfr_pkg::SFR_CS_PROG: begin
				if (cnt_q == 16'(`SFR_PROG_CYC - 1)) begin
					latch_d = 1'b0;
					cstate_d = sfr_pkg::SFR_CS_IDLE;
				end
			end
			sfr_pkg::SFR_CS_ERASE: begin
				mem_we = 1'b1;
				mem_waddr = cnt_q[`SFR_MEM_AW-1:0];
				mem_wdata = `SFR_ERASED_BYTE;
				if (cnt_q == 16'(`SFR_MEM_BYTES - 1)) begin
					latch_d = 1'b0;
					cstate_d = sfr_pkg::SFR_CS_IDLE;
				end
			end
		endcase
		// Requests that meet a running cycle are answered, not silently dropped.
		if (busy && (prog_req_in || erase_req_in)) begin
			refused_d = 1'b1;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cstate_q <= sfr_pkg::SFR_CS_IDLE;
			lock_q <= `SFR_LOCK_RST;
			qe_q <= `SFR_QE_RST;
			bp_q <= `SFR_BP_RST;
			tb_q <= `SFR_TB_RST;
			latch_q <= 1'b0;
			hw_q <= 1'b0;
			refused_q <= 1'b0;
			cs_prev_q <= 1'b1;
			cnt_q <= 16'h0000;
		end else begin
			cstate_q <= cstate_d;
			lock_q <= lock_d;
			qe_q <= qe_d;
			bp_q <= bp_d;
			tb_q <= tb_d;
			latch_q <= latch_d;
			hw_q <= hw_d;
			refused_q <= refused_d;
			cs_prev_q <= cs_hi;
			cnt_q <= cnt_d;
		end
	end

	// The array has no reset; software erases it before trusting its contents.
	always_ff @(posedge ref_clk_in) begin
		if (mem_we) begin
			mem_q[mem_waddr] <= mem_wdata;
		end
	end

	assign status_write_lock_out = lock_q;
	assign quad_enable_bit_out = qe_q;
	assign block_protect_bits_out = bp_q;
	assign protect_region_select_out = tb_q;
	assign write_latch_out = latch_q;
	assign busy_out = busy;
	assign hardware_protect_state_out = hw_q;
	assign software_protect_state_out = ~hw_q;
	assign refused_out = refused_q;
endmodule // sfr_top
`default_nettype wire

// ==== verification/sfr_top_checker.sv ====
// Concurrent checks on the ports of the flash read and protection block.
`timescale 1ns/100ps
`default_nettype none
module sfr_top_checker (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic sclk_in,
	input wire logic cs_n_in,
	input wire logic io_line_2_in,
	input wire logic prog_req_in,
	input wire logic io_line_0_out,
	input wire logic io_line_1_out,
	input wire logic io_line_0_oe_out,
	input wire logic io_line_1_oe_out,
	input wire logic io_line_2_oe_out,
	input wire logic io_line_3_oe_out,
	input wire logic status_write_lock_out,
	input wire logic quad_enable_bit_out,
	input wire logic [3:0] block_protect_bits_out,
	input wire logic write_latch_out,
	input wire logic busy_out,
	input wire logic hardware_protect_state_out,
	input wire logic software_protect_state_out,
	input wire logic refused_out
);
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);
	// Eight cycles cover the pin synchroniser plus the state register.
	property p_hw_entry;
		(status_write_lock_out && !io_line_2_in && !quad_enable_bit_out)[*8]
			|-> hardware_protect_state_out;
	endproperty
	a_hw_entry: assert property (p_hw_entry) else $error("protection state not entered");
	property p_sw_stay;
		(status_write_lock_out && io_line_2_in)[*8]
			|-> software_protect_state_out && !hardware_protect_state_out;
	endproperty
	a_sw_stay: assert property (p_sw_stay) else $error("software state lost");
	property p_hw_hold;
		hardware_protect_state_out && !io_line_2_in && !quad_enable_bit_out
			|=> hardware_protect_state_out;
	endproperty
	a_hw_hold: assert property (p_hw_hold) else $error("protection left with pin low");
	property p_quad;
		quad_enable_bit_out[*2] |-> !hardware_protect_state_out;
	endproperty
	a_quad: assert property (p_quad) else $error("protection active in quad mode");
	property p_prot;
		prog_req_in && !busy_out && (block_protect_bits_out == 4'hf) |=> refused_out && !busy_out;
	endproperty
	a_prot: assert property (p_prot) else $error("protected program accepted");
	property p_oe_rel;
		cs_n_in |-> {io_line_0_oe_out, io_line_1_oe_out, io_line_2_oe_out, io_line_3_oe_out} == 4'h0;
	endproperty
	a_oe_rel: assert property (p_oe_rel) else $error("line driven while deselected");
	property p_fall_shift;
		sclk_in && $past(sclk_in) |-> $stable(io_line_1_out) && $stable(io_line_0_out);
	endproperty
	a_fall_shift: assert property (p_fall_shift) else $error("data moved while clock high");
	property p_hw_lock;
		hardware_protect_state_out && $past(hardware_protect_state_out)
			|-> $stable(status_write_lock_out) && $stable(block_protect_bits_out);
	endproperty
	a_hw_lock: assert property (p_hw_lock) else $error("status changed under protection");
	property p_latch_clr;
		$fell(busy_out) |-> !write_latch_out;
	endproperty
	a_latch_clr: assert property (p_latch_clr) else $error("latch kept after cycle");
	c_read: cover property ($rose(io_line_1_oe_out));
	c_hw: cover property ($rose(hardware_protect_state_out));
	c_refused: cover property (refused_out);
endmodule // sfr_top_checker
bind sfr_top sfr_top_checker u_chk (.ref_clk_in, .rst_n_in, .sclk_in, .cs_n_in, .io_line_2_in,
	.prog_req_in, .io_line_0_out, .io_line_1_out, .io_line_0_oe_out, .io_line_1_oe_out,
	.io_line_2_oe_out, .io_line_3_oe_out, .status_write_lock_out, .quad_enable_bit_out,
	.block_protect_bits_out, .write_latch_out, .busy_out, .hardware_protect_state_out,
	.software_protect_state_out, .refused_out);
`default_nettype wire

// ==== verification/sfr_host_model.sv ====
// Behavioural host serial controller that frames commands towards the flash block.
`timescale 1ns/100ps
`default_nettype none
module sfr_host_model (
	output logic sclk_out,
	output logic cs_n_out,
	output logic [3:0] hv_out,
	output logic [3:0] hoe_out,
	input wire logic wp_in,
	input wire logic [3:0] line_in
);
	logic [3:0] hv_q;
	assign hv_out = {hv_q[3], wp_in, hv_q[1:0]};
	initial begin
		sclk_out = 1'b0;
		cs_n_out = 1'b1;
		hv_q = 4'h0;
		hoe_out = 4'h4;
	end
	task automatic edge_clk(output logic [3:0] s);
		#16 sclk_out = 1'b1;
		s = line_in;
		#16 sclk_out = 1'b0;
	endtask
	task automatic frame(input logic [7:0] cmd, input logic [23:0] a, input int abits,
			input logic dual, input int dum, input int w, input int nclk, output logic [15:0] rd);
		logic [3:0] s;
		int i;
		rd = 16'h0000;
		cs_n_out = 1'b0;
		hoe_out = 4'h7;
		#16;
		for (i = 7; i >= 0; i--) begin
			hv_q[0] = cmd[i];
			edge_clk(s);
		end
		for (i = 0; i < abits; i++) begin
			if (dual) hv_q[1:0] = a[23 - 2 * i -: 2];
			else hv_q[0] = a[23 - i];
			edge_clk(s);
		end
		hv_q[1:0] = 2'b00;
		for (i = 0; i < dum; i++) edge_clk(s);
		hoe_out = (w == 1) ? 4'h5 : (w == 2) ? 4'h4 : 4'h0;
		for (i = 0; i < nclk; i++) begin
			edge_clk(s);
			rd = (w == 1) ? {rd[14:0], s[1]} : (w == 2) ? {rd[13:0], s[1:0]} : {rd[11:0], s};
		end
		#8 cs_n_out = 1'b1;
		hoe_out = 4'h4;
		#200;
	endtask
endmodule // sfr_host_model
`default_nettype wire

// ==== verification/sfr_top_tb.sv ====
// Self-checking testbench for the flash read and protection block.
`timescale 1ns/100ps
`default_nettype none
`include "sfr_cfg.svh"
module sfr_top_tb;
	typedef struct packed {
		logic [7:0] cmd;
		logic [23:0] addr;
		logic dual;
		logic [3:0] dum;
		logic [2:0] w;
		logic [15:0] exp;
	} sfr_row_t;
	sfr_row_t rows [6] = '{
		'{`SFR_CMD_READ, 24'h00_0005, 1'b0, 4'h0, 3'h1, 16'ha53c},
		'{`SFR_CMD_FAST, 24'h00_0005, 1'b0, 4'h8, 3'h1, 16'ha53c},
		'{`SFR_CMD_DOUT, 24'h00_0005, 1'b0, 4'h8, 3'h2, 16'ha53c},
		'{`SFR_CMD_DIO, 24'h00_0005, 1'b1, 4'h4, 3'h2, 16'ha53c},
		'{`SFR_CMD_QOUT, 24'h00_0005, 1'b0, 4'h8, 3'h4, 16'ha53c},
		'{`SFR_CMD_READ, 24'hff_ffff, 1'b0, 4'h0, 3'h1, 16'hff12}};
	logic clk = 1'b0, rst_n = 1'b0, prog_req = 1'b0, erase_req = 1'b0, wp = 1'b1, flt_q = 1'b0;
	logic [23:0] prog_addr = 24'h00_0000;
	logic [7:0] prog_data = 8'h00;
	logic sclk, cs_n, lock, qe, tb_sel, latch, busy, hw, sw, refused, oe_seen, ref_seen;
	logic cs_busy;
	logic [3:0] hv, hoe, line, dev_o, dev_oe, bp;
	logic [15:0] rd;
	int miscompares = 0, num_checks = 0, i;
	// Undriven lines toggle so a stale value can never pass for data.
	assign line = (dev_oe & dev_o) | (~dev_oe & hoe & hv) | (~dev_oe & ~hoe & {4{flt_q}});
	always #5 clk = ~clk;
	always @(posedge clk) flt_q <= ~flt_q;
	always @(posedge sclk) if (|dev_oe) oe_seen = 1'b1;
	always @(posedge clk) if (refused) ref_seen <= 1'b1;
	// The status write can end before the frame task returns, so busy is taken as the frame closes.
	always @(posedge cs_n) cs_busy = busy;
	sfr_host_model u_host (.sclk_out(sclk), .cs_n_out(cs_n), .hv_out(hv), .hoe_out(hoe),
		.wp_in(wp), .line_in(line));
	sfr_top u_dut (.ref_clk_in(clk), .rst_n_in(rst_n), .sclk_in(sclk), .cs_n_in(cs_n),
		.io_line_0_in(line[0]), .io_line_0_out(dev_o[0]), .io_line_0_oe_out(dev_oe[0]),
		.io_line_1_in(line[1]), .io_line_1_out(dev_o[1]), .io_line_1_oe_out(dev_oe[1]),
		.io_line_2_in(line[2]), .io_line_2_out(dev_o[2]), .io_line_2_oe_out(dev_oe[2]),
		.io_line_3_in(line[3]), .io_line_3_out(dev_o[3]), .io_line_3_oe_out(dev_oe[3]),
		.prog_req_in(prog_req), .erase_req_in(erase_req), .prog_addr_in(prog_addr),
		.prog_data_in(prog_data), .status_write_lock_out(lock), .quad_enable_bit_out(qe),
		.block_protect_bits_out(bp), .protect_region_select_out(tb_sel),
		.write_latch_out(latch), .busy_out(busy), .hardware_protect_state_out(hw),
		.software_protect_state_out(sw), .refused_out(refused));
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic conclude();
		$display("checks=%0d mismatches=%0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 6000) begin
			@(negedge clk);
			n++;
		end
		if (n >= 6000) check(32'h1, 32'h0);
	endtask
	task automatic core(input logic e, input logic [23:0] a, input logic [7:0] d);
		@(negedge clk);
		{prog_req, erase_req, prog_addr, prog_data} = {~e, e, a, d};
		@(negedge clk);
		{prog_req, erase_req} = 2'b00;
		@(negedge clk);
		wait_idle();
	endtask
	task automatic write_enable_cmd();
		u_host.frame(`SFR_CMD_WRITE_ENABLE_CMD, 24'h00_0000, 0, 1'b0, 0, 1, 0, rd);
	endtask
	task automatic swr(input logic [7:0] b);
		write_enable_cmd();
		u_host.frame(`SFR_CMD_SWRITE, {b, 16'h0000}, 8, 1'b0, 0, 1, 0, rd);
		@(negedge clk);
		wait_idle();
	endtask
	task automatic settle(input logic v);
		@(negedge clk);
		wp = v;
		repeat (8) @(negedge clk);
	endtask
	initial begin
		#400000;
		miscompares++;
		conclude();
	end
	initial begin
		repeat (12) @(negedge clk);
		check({lock, qe, bp, tb_sel, latch, busy, hw, sw, refused, |dev_oe}, 13'h0004);
		rst_n = 1'b1;
		repeat (10) @(negedge clk);
		write_enable_cmd();
		core(1'b1, 24'h00_0000, 8'h00);
		write_enable_cmd();
		core(1'b0, 24'h00_0005, 8'ha5);
		write_enable_cmd();
		core(1'b0, 24'h00_0006, 8'h3c);
		write_enable_cmd();
		core(1'b0, 24'h00_0000, 8'h12);
		check(latch, 1'b0);
		for (i = 0; i < 6; i++) begin
			u_host.frame(rows[i].cmd, rows[i].addr, rows[i].dual ? 12 : 24, rows[i].dual,
				int'(rows[i].dum), int'(rows[i].w), 16 / int'(rows[i].w), rd);
			check(rd, rows[i].exp);
			check(dev_oe, 4'h0);
		end
		for (i = 1; i < 5; i++) begin
			write_enable_cmd();
			u_host.frame(`SFR_CMD_SWRITE, 24'h00_0000, 8, 1'b0, 0, 1, 0, rd);
			oe_seen = 1'b0;
			u_host.frame(rows[i].cmd, rows[i].addr, rows[i].dual ? 12 : 24, rows[i].dual,
				int'(rows[i].dum), int'(rows[i].w), 16 / int'(rows[i].w), rd);
			check({cs_busy, oe_seen}, 2'b10);
			wait_idle();
		end
		settle(1'b0);
		swr(8'h80);
		repeat (8) @(negedge clk);
		check({lock, hw, sw}, 3'b110);
		settle(1'b1);
		check({lock, hw, sw}, 3'b101);
		settle(1'b0);
		check(hw, 1'b1);
		swr(8'h00);
		check({lock, busy}, 2'b10);
		settle(1'b1);
		swr(8'hbc);
		check({lock, bp, sw}, 6'h3f);
		ref_seen = 1'b0;
		write_enable_cmd();
		core(1'b0, 24'h00_0100, 8'h00);
		check({busy, ref_seen}, 2'b01);
		swr(8'hc0);
		settle(1'b0);
		check({qe, hw}, 2'b10);
		swr(8'h00);
		check({lock, qe}, 2'b00);
		settle(1'b1);
		// A 24-clock status write also carries the one-way region select bit.
		write_enable_cmd();
		u_host.frame(`SFR_CMD_SWRITE, 24'h04_0800, 16, 1'b0, 0, 1, 0, rd);
		@(negedge clk);
		wait_idle();
		check({bp, tb_sel}, 5'h03);
		ref_seen = 1'b0;
		write_enable_cmd();
		core(1'b0, 24'h00_0200, 8'h00);
		check({busy, ref_seen}, 2'b01);
		conclude();
	end
endmodule // sfr_top_tb
`default_nettype wire
